//--- design/iosmd_pkg.sv
// Package of constants and types for the I/O status and maintenance display
package iosmd_pkg;

    // ****************************************
    // Status word layout
    // ****************************************
    localparam int IN_FWD_BIT    = 0;
    localparam int IN_REV_BIT    = 1;
    localparam int IN_GEN1_BIT   = 2;
    localparam int IN_CMD_FWD    = 13;
    localparam int IN_CMD_REV    = 14;
    localparam int IN_CMD_RST    = 15;
    localparam int OUT_TR_BIT    = 0;
    localparam int OUT_RELAY_BIT = 8;

    // ****************************************
    // Menus and timing
    // ****************************************
    localparam logic [1:0]  MENU_FULL         = 2'h2;
    localparam logic [15:0] HOURS_FINE_LIMIT  = 16'h2710;
    localparam logic [15:0] HOURS_WRAP        = 16'hFFFF;
    localparam int          CLK_HZ            = 250000000;
    localparam int          HOUR_S            = 3600;
    localparam longint      HOUR_CYCLES       = longint'(CLK_HZ) * longint'(HOUR_S);
    localparam logic [15:0] STAT_RESET        = 16'h0000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_MENU     = 3'b001,
        ST_IO_LIST  = 3'b010,
        ST_IO_DATA  = 3'b011,
        ST_MNT_LIST = 3'b100,
        ST_MNT_DATA = 3'b101
    } iosmd_mode_type;

    typedef struct packed {
        logic forward_run_input;
        logic reverse_run_input;
        logic general_input_1;
        logic general_input_2;
        logic general_input_3;
        logic transistor_output;
        logic relay_normally_open_contact;
    } iosmd_term_type;

    typedef struct packed {
        logic comm_forward_command;
        logic comm_reverse_command;
        logic comm_reset_command;
    } iosmd_comm_type;

    typedef struct packed {
        logic key_prg;
        logic key_up;
        logic key_down;
        logic key_func;
    } iosmd_keys_type;

endpackage

//--- design/iosmd_hex_digit.sv
// One nibble to seven-segment pattern converter, registered
`timescale 1ns/1ps
`default_nettype none
module iosmd_hex_digit (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_nibble,
    output var  logic [6:0] o_seg
);
    logic [6:0] seg_d;
    logic [6:0] seg_q;

    // ****************************************
    // Decode, segments g..a
    // ****************************************
    always_comb begin
        case (i_nibble)
            4'h0: seg_d = 7'h3F;
            4'h1: seg_d = 7'h06;
            4'h2: seg_d = 7'h5B;
            4'h3: seg_d = 7'h4F;
            4'h4: seg_d = 7'h66;
            4'h5: seg_d = 7'h6D;
            4'h6: seg_d = 7'h7D;
            4'h7: seg_d = 7'h07;
            4'h8: seg_d = 7'h7F;
            4'h9: seg_d = 7'h6F;
            4'hA: seg_d = 7'h77;
            4'hB: seg_d = 7'h7C;
            4'hC: seg_d = 7'h39;
            4'hD: seg_d = 7'h5E;
            4'hE: seg_d = 7'h79;
            4'hF: seg_d = 7'h71;
            default: seg_d = 7'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            seg_q <= 7'h00;
        end else begin
            seg_q <= seg_d;
        end
    end

    assign o_seg = seg_q;
endmodule
`default_nettype wire

//--- design/iosmd_top.sv
// I/O status words, maintenance readouts and four-digit display
// Behaviour
// - Forward-run input goes to bit 0 and reverse-run input to bit 1 of the input word.
// - General inputs 1 to 3 go to bits 2, 3 and 4 of the input word.
// - An input bit is 1 when its terminal is shorted to the selected common, 0 when open.
// - Unassigned bits of a status word read zero.
// - The word is shown as four hex digits, leftmost holding bits 15 to 12.
// - Output bit 0 is 1 while the transistor output conducts.
// - Output bit 8 is 1 when the relay normally-open contact is closed.
// - Under link control the forward, reverse and reset commands go to bits 13, 14, 15.
// - Under link control the commands are shown uninverted in I/O data items 1 and 3 to 7; item 0 masks them out.
// - Power-on hours accumulate, shown in 1 h steps below 10000 h, 10 h above, wrapping.
// - The DC link voltage is offered as a maintenance readout.
// - The hourly peak heat-sink temperature is tracked and offered.
// - The hourly peak effective current is tracked and offered.
// - I/O check and maintenance menus open only at full-menu level.
// - Power-up enters running mode; keys walk menu, list, data and back.
`timescale 1ns/1ps
`default_nettype none
module iosmd_top
    import iosmd_pkg::*;
#(
    parameter longint HOUR_LEN = HOUR_CYCLES
) (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst,
    input  wire iosmd_pkg::iosmd_term_type i_term,
    input  wire iosmd_pkg::iosmd_comm_type i_comm,
    input  wire logic                      i_comm_control,
    input  wire logic [1:0]                i_menu_level_setting,
    input  wire iosmd_pkg::iosmd_keys_type i_keys,
    input  wire logic [15:0]               i_dc_link_volts,
    input  wire logic [15:0]               i_heatsink_temp,
    input  wire logic [15:0]               i_eff_current,
    output var  logic [2:0]                o_mode,
    output var  logic [2:0]                o_item,
    output var  logic [15:0]               o_in_status,
    output var  logic [15:0]               o_out_status,
    output var  logic [15:0]               o_hours,
    output var  logic [15:0]               o_hours_shown,
    output var  logic                      o_hours_coarse,
    output var  logic [15:0]               o_peak_temp,
    output var  logic [15:0]               o_peak_current,
    output var  logic [27:0]               o_segments
);
    import iosmd_pkg::*;

    // ****************************************
    // Status words
    // ****************************************
    logic [15:0] in_d, in_q, out_d, out_q;

    always_comb begin
        in_d = STAT_RESET;
        in_d[IN_FWD_BIT] = i_term.forward_run_input;
        in_d[IN_REV_BIT] = i_term.reverse_run_input;
        in_d[IN_GEN1_BIT]     = i_term.general_input_1;
        in_d[IN_GEN1_BIT + 1] = i_term.general_input_2;
        in_d[IN_GEN1_BIT + 2] = i_term.general_input_3;
        if (i_comm_control) begin
            in_d[IN_CMD_FWD] = i_comm.comm_forward_command;
            in_d[IN_CMD_REV] = i_comm.comm_reverse_command;
            in_d[IN_CMD_RST] = i_comm.comm_reset_command;
        end
        out_d = STAT_RESET;
        out_d[OUT_TR_BIT]    = i_term.transistor_output;
        out_d[OUT_RELAY_BIT] = i_term.relay_normally_open_contact;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            in_q  <= STAT_RESET;
            out_q <= STAT_RESET;
        end else begin
            in_q  <= in_d;
            out_q <= out_d;
        end
    end

    // ****************************************
    // Hour tick and maintenance counters
    // ****************************************
    logic [63:0] tick_cnt_d, tick_cnt_q;
    logic        hour_tick;
    logic [15:0] hours_d, hours_q, shown_d, shown_q;
    logic        coarse_d, coarse_q;
    logic [15:0] ptemp_d, ptemp_q, pcur_d, pcur_q, htemp_d, htemp_q, hcur_d, hcur_q;

    always_comb begin
        hour_tick  = (tick_cnt_q == 64'(HOUR_LEN - 1));
        tick_cnt_d = hour_tick ? 64'h0 : tick_cnt_q + 64'h1;
        hours_d    = hours_q;
        if (hour_tick) begin
            hours_d = (hours_q == HOURS_WRAP) ? 16'h0000 : hours_q + 16'h0001;
        end
        coarse_d = (hours_q >= HOURS_FINE_LIMIT);
        shown_d  = coarse_d ? 16'(hours_q / 16'h000A) : hours_q;
        // Running peaks within the hour
        htemp_d = (i_heatsink_temp > htemp_q) ? i_heatsink_temp : htemp_q;
        hcur_d  = (i_eff_current > hcur_q) ? i_eff_current : hcur_q;
        ptemp_d = ptemp_q;
        pcur_d  = pcur_q;
        if (hour_tick) begin
            ptemp_d = htemp_d;
            pcur_d  = hcur_d;
            htemp_d = i_heatsink_temp;
            hcur_d  = i_eff_current;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tick_cnt_q <= 64'h0;
            hours_q    <= 16'h0000;
            shown_q    <= 16'h0000;
            coarse_q   <= 1'b0;
            htemp_q    <= 16'h0000;
            hcur_q     <= 16'h0000;
            ptemp_q    <= 16'h0000;
            pcur_q     <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            hours_q    <= hours_d;
            shown_q    <= shown_d;
            coarse_q   <= coarse_d;
            htemp_q    <= htemp_d;
            hcur_q     <= hcur_d;
            ptemp_q    <= ptemp_d;
            pcur_q     <= pcur_d;
        end
    end

    // ****************************************
    // Keypad menu walk
    // ****************************************
    iosmd_mode_type mode_d, mode_q;
    logic [2:0]     item_d, item_q;
    logic           full_menu;
    logic           menu_sel_d, menu_sel_q;
    logic [15:0]    view_d, view_q;

    always_comb begin
        full_menu  = (i_menu_level_setting == MENU_FULL);
        mode_d     = mode_q;
        item_d     = item_q;
        menu_sel_d = menu_sel_q;
        if (i_keys.key_up) begin
            if (mode_q == ST_MENU) menu_sel_d = ~menu_sel_q;
            else item_d = item_q + 3'h1;
        end else if (i_keys.key_down) begin
            if (mode_q == ST_MENU) menu_sel_d = ~menu_sel_q;
            else item_d = item_q - 3'h1;
        end
        case (mode_q)
            ST_RUN: begin
                if (i_keys.key_prg) mode_d = ST_MENU;
            end
            ST_MENU: begin
                if (i_keys.key_prg) begin
                    mode_d = ST_RUN;
                end else if (i_keys.key_func && full_menu) begin
                    mode_d = menu_sel_q ? ST_MNT_LIST : ST_IO_LIST;
                    item_d = 3'h0;
                end
            end
            ST_IO_LIST: begin
                if (i_keys.key_prg) mode_d = ST_MENU;
                else if (i_keys.key_func) mode_d = ST_IO_DATA;
            end
            ST_MNT_LIST: begin
                if (i_keys.key_prg) mode_d = ST_MENU;
                else if (i_keys.key_func) mode_d = ST_MNT_DATA;
            end
            ST_IO_DATA: begin
                if (i_keys.key_prg) mode_d = ST_IO_LIST;
            end
            ST_MNT_DATA: begin
                if (i_keys.key_prg) mode_d = ST_MNT_LIST;
            end
            default: mode_d = ST_RUN;
        endcase
        if (!full_menu && mode_q != ST_RUN && mode_q != ST_MENU) begin
            mode_d = ST_MENU;
        end
        // Word selected for the display
        case (mode_q)
            ST_IO_DATA: begin
                case (item_q)
                    3'h0: view_d = {in_q[15:13] & 3'h0, in_q[12:0]} | out_q;
                    3'h1: view_d = in_q | out_q;
                    3'h2: view_d = out_q;
                    default: view_d = in_q;
                endcase
            end
            ST_MNT_DATA: begin
                case (item_q)
                    3'h0: view_d = shown_q;
                    3'h1: view_d = i_dc_link_volts;
                    3'h2: view_d = ptemp_q;
                    3'h3: view_d = pcur_q;
                    default: view_d = shown_q;
                endcase
            end
            default: view_d = {13'h0000, item_q};
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mode_q     <= ST_RUN;
            item_q     <= 3'h0;
            menu_sel_q <= 1'b0;
            view_q     <= 16'h0000;
        end else begin
            mode_q     <= mode_d;
            item_q     <= item_d;
            menu_sel_q <= menu_sel_d;
            view_q     <= view_d;
        end
    end

    // ****************************************
    // Four hex digits
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_digit
            iosmd_hex_digit u_digit (
                .i_sys_clk (i_sys_clk),
                .i_rst     (i_rst),
                .i_nibble  (view_q[4*g +: 4]),
                .o_seg     (o_segments[7*g +: 7])
            );
        end
    endgenerate

    assign o_mode         = mode_q;
    assign o_item         = item_q;
    assign o_in_status    = in_q;
    assign o_out_status   = out_q;
    assign o_hours        = hours_q;
    assign o_hours_shown  = shown_q;
    assign o_hours_coarse = coarse_q;
    assign o_peak_temp    = ptemp_q;
    assign o_peak_current = pcur_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    input_bits_a: assert property (##1 o_in_status[1:0] ==
        {$past(i_term.reverse_run_input), $past(i_term.forward_run_input)})
        else $error("run inputs misplaced");
    gen_inputs_a: assert property (##1 o_in_status[4:2] == {$past(i_term.general_input_3),
        $past(i_term.general_input_2), $past(i_term.general_input_1)})
        else $error("general inputs misplaced");
    closed_reads_one_a: assert property (i_term.forward_run_input |=> o_in_status[0])
        else $error("closed input not one");
    unused_zero_a: assert property (o_in_status[12:5] == 8'h00 && o_out_status[15:9] == 7'h00
        && o_out_status[7:1] == 7'h00)
        else $error("unassigned bit set");
    digit_order_a: assert property (mode_q == ST_MNT_DATA && item_q == 3'h1
        && i_dc_link_volts[15:12] == 4'h8 |=> ##1 o_segments[27:21] == 7'h7F)
        else $error("digit order wrong");
    tr_out_a: assert property (i_term.transistor_output |=> o_out_status[0])
        else $error("transistor bit wrong");
    relay_a: assert property (##1 o_out_status[8] == $past(i_term.relay_normally_open_contact))
        else $error("relay bit wrong");
    comm_bits_a: assert property (i_comm_control && i_comm.comm_reset_command
        |=> o_in_status[15])
        else $error("comm bit missing");
    comm_off_a: assert property (!i_comm_control |=> o_in_status[15:13] == 3'h0)
        else $error("comm bits outside link control");
    hours_wrap_a: assert property (hour_tick && hours_q == HOURS_WRAP |=> hours_q == 16'h0000)
        else $error("hour wrap failed");
    hours_step_a: assert property (hour_tick && hours_q != HOURS_WRAP
        |=> hours_q == $past(hours_q) + 16'h0001)
        else $error("hour step failed");
    volts_a: assert property (mode_q == ST_MNT_DATA && item_q == 3'h1
        |=> view_q == $past(i_dc_link_volts))
        else $error("volts view wrong");
    peak_temp_a: assert property (!hour_tick && i_heatsink_temp > htemp_q
        |=> htemp_q == $past(i_heatsink_temp))
        else $error("temp peak missed");
    peak_cur_a: assert property (hour_tick |=> pcur_q >= $past(hcur_q))
        else $error("current peak lost");
    menu_gate_a: assert property (!full_menu |=> mode_q inside {ST_RUN, ST_MENU})
        else $error("menu reached without full level");
    run_to_menu_a: assert property (mode_q == ST_RUN && i_keys.key_prg |=> mode_q == ST_MENU)
        else $error("program key ignored");
    peak_restart_a: assert property (hour_tick |=> htemp_q == $past(i_heatsink_temp))
        else $error("peak not restarted");

    io_view_c: cover property (mode_q == ST_IO_DATA);
    mnt_view_c: cover property (mode_q == ST_MNT_DATA);
    coarse_c: cover property (coarse_q);
    comm_c: cover property (i_comm_control && o_in_status[13]);
endmodule
`default_nettype wire

//--- sim/iosmd_panel.sv
// LED monitor model: reads the four seven-segment digits back as hex
`timescale 1ns/1ps
`default_nettype none
module iosmd_panel (
    input  wire logic [27:0] i_segments,
    output var  logic [15:0] o_digits
);
    import iosmd_pkg::*;
    // ****************************************
    // Segment decode
    // ****************************************
    function automatic logic [3:0] seg_to_hex(input logic [6:0] s);
        case (s)
            7'h3F: seg_to_hex = 4'h0;
            7'h06: seg_to_hex = 4'h1;
            7'h5B: seg_to_hex = 4'h2;
            7'h4F: seg_to_hex = 4'h3;
            7'h66: seg_to_hex = 4'h4;
            7'h6D: seg_to_hex = 4'h5;
            7'h7D: seg_to_hex = 4'h6;
            7'h07: seg_to_hex = 4'h7;
            7'h7F: seg_to_hex = 4'h8;
            7'h6F: seg_to_hex = 4'h9;
            7'h77: seg_to_hex = 4'hA;
            7'h7C: seg_to_hex = 4'hB;
            7'h39: seg_to_hex = 4'hC;
            7'h5E: seg_to_hex = 4'hD;
            7'h79: seg_to_hex = 4'hE;
            7'h71: seg_to_hex = 4'hF;
            default: seg_to_hex = 4'hX;
        endcase
    endfunction
    // Digit 3 is the leftmost and holds the top nibble
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_digits[4*k +: 4] = seg_to_hex(i_segments[7*k +: 7]);
        end
    end
endmodule
`default_nettype wire

//--- sim/iosmd_tb_top.sv
// Self-checking testbench of the I/O status and maintenance display
`timescale 1ns/1ps
`default_nettype none
module iosmd_tb_top;
    import iosmd_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    localparam longint         HLEN  = 4;
    localparam iosmd_keys_type K_PRG = 4'h8;
    localparam iosmd_keys_type K_UP  = 4'h4;
    localparam iosmd_keys_type K_DN  = 4'h2;
    localparam iosmd_keys_type K_FN  = 4'h1;
    logic           sys_clk = 1'b0;
    logic           rst     = 1'b1;
    iosmd_term_type term    = '0;
    iosmd_comm_type comm    = '0;
    logic           ctl     = 1'b0;
    logic [1:0]     lvl     = 2'h2;
    iosmd_keys_type keys    = '0;
    logic [15:0]    volts   = 16'h8258;
    logic [15:0]    temp    = 16'h0010;
    logic [15:0]    cur     = 16'h0020;
    logic [2:0]     mode, item;
    logic [15:0]    in_st, out_st, hours, shown, pk_t, pk_c, digits;
    logic           coarse;
    logic [27:0]    segs;
    int             n_fail = 0, checks_done = 0, cyc = 0, seed = 59471;

    iosmd_top #(.HOUR_LEN(HLEN)) iosmd_top_i (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_term(term), .i_comm(comm),
        .i_comm_control(ctl), .i_menu_level_setting(lvl), .i_keys(keys),
        .i_dc_link_volts(volts), .i_heatsink_temp(temp), .i_eff_current(cur),
        .o_mode(mode), .o_item(item), .o_in_status(in_st), .o_out_status(out_st),
        .o_hours(hours), .o_hours_shown(shown), .o_hours_coarse(coarse),
        .o_peak_temp(pk_t), .o_peak_current(pk_c), .o_segments(segs));
    iosmd_panel iosmd_panel_i (.i_segments(segs), .o_digits(digits));

    initial forever #2 sys_clk = ~sys_clk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] exp_in(iosmd_term_type t, iosmd_comm_type c, logic l);
        logic [15:0] w;
        w = 16'h0000;
        w[IN_FWD_BIT] = t.forward_run_input;
        w[IN_REV_BIT] = t.reverse_run_input;
        w[IN_GEN1_BIT] = t.general_input_1;
        w[IN_GEN1_BIT+1] = t.general_input_2;
        w[IN_GEN1_BIT+2] = t.general_input_3;
        if (l) begin
            w[IN_CMD_FWD] = c.comm_forward_command;
            w[IN_CMD_REV] = c.comm_reverse_command;
            w[IN_CMD_RST] = c.comm_reset_command;
        end
        return w;
    endfunction
    function automatic logic [15:0] exp_out(iosmd_term_type t);
        logic [15:0] w;
        w = 16'h0000;
        w[OUT_TR_BIT] = t.transistor_output;
        w[OUT_RELAY_BIT] = t.relay_normally_open_contact;
        return w;
    endfunction
    function automatic logic [15:0] exp_view(logic [2:0] it, iosmd_term_type t,
                                             iosmd_comm_type c, logic l);
        case (it)
            3'h0: return exp_in(t, c, 1'b0) | exp_out(t);
            3'h1: return exp_in(t, c, l) | exp_out(t);
            3'h2: return exp_out(t);
            default: return exp_in(t, c, l);
        endcase
    endfunction
    task automatic press(input iosmd_keys_type k, input logic [2:0] m);
        @(negedge sys_clk) keys = k;
        @(negedge sys_clk) keys = '0;
        repeat (2) @(negedge sys_clk);
        check("mode", {13'h0000, m}, {13'h0000, mode});
    endtask
    task automatic rand_io(input int n, input logic [2:0] it);
        logic [31:0] rv;
        for (int i = 0; i < n; i++) begin
            rv = $random(seed);
            @(negedge sys_clk);
            term = (i == 0) ? 7'h50 : rv[6:0];
            comm = (i == 0) ? 3'h7 : rv[9:7];
            ctl = (i == 0) ? 1'b0 : rv[10];
            repeat (5) @(negedge sys_clk);
            check("in word", exp_in(term, comm, ctl), in_st);
            check("out word", exp_out(term), out_st);
            check("digits", exp_view(it, term, comm, ctl), digits);
        end
    endtask
    task automatic wait_tick();
        logic [15:0] h;
        h = hours;
        for (int i = 0; i < 20 && hours === h; i++) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic wait_hours(input logic [15:0] v);
        for (int i = 0; i < 50000 && hours !== v; i++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            complete_run();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        check("reset mode", 16'h0000, {13'h0000, mode});
        check("reset in", 16'h0000, in_st);
        press(K_PRG, ST_MENU);
        press(K_FN, ST_IO_LIST);
        press(K_UP, ST_IO_LIST);
        press(K_UP, ST_IO_LIST);
        check("item", 16'h0002, {13'h0000, item});
        press(K_FN, ST_IO_DATA);
        rand_io(12, 3'h2);
        press(K_UP, ST_IO_DATA);
        rand_io(12, 3'h3);
        press(K_DN, ST_IO_DATA);
        press(K_DN, ST_IO_DATA);
        rand_io(6, 3'h1);
        press(K_DN, ST_IO_DATA);
        rand_io(6, 3'h0);
        press(K_PRG, ST_IO_LIST);
        press(K_PRG, ST_MENU);
        press(K_UP, ST_MENU);
        press(K_FN, ST_MNT_LIST);
        press(K_UP, ST_MNT_LIST);
        press(K_FN, ST_MNT_DATA);
        repeat (4) @(negedge sys_clk);
        check("volts shown", volts, digits);
        press(K_DN, ST_MNT_DATA);
        wait_tick();
        repeat (2) @(negedge sys_clk);
        check("hours view", hours, digits);
        lvl = 2'h1;
        repeat (3) @(negedge sys_clk);
        check("level drop", {13'h0000, ST_MENU}, {13'h0000, mode});
        press(K_FN, ST_MENU);
        press(K_PRG, ST_RUN);
        wait_tick();
        temp = 16'h0FA0;
        cur = 16'h01F4;
        @(negedge sys_clk);
        temp = 16'h0010;
        cur = 16'h0020;
        wait_tick();
        check("peak temp", 16'h0FA0, pk_t);
        check("peak current", 16'h01F4, pk_c);
        wait_tick();
        check("peak temp restart", 16'h0010, pk_t);
        check("peak current restart", 16'h0020, pk_c);
        wait_hours(16'h270F);
        check("fine hours", 16'h270F, shown);
        check("raw hours", 16'h270F, hours);
        check("fine flag", 16'h0000, {15'h0000, coarse});
        wait_hours(16'h2774);
        check("coarse hours", 16'h03F2, shown);
        check("coarse flag", 16'h0001, {15'h0000, coarse});
        complete_run();
    end
endmodule
`default_nettype wire
